// ### inc/clk_regs_pkg.sv
// Constants for the clock, alignment reference and full-scale register group
package clk_regs_pkg;
    // Serial frame layout
    localparam int ADDR_W = 15;
    localparam int HDR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int RW_BIT = 15;
    localparam logic [4:0] HDR_LAST = 5'h0F;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    // Byte addresses
    localparam logic [14:0] ADDR_DELAY_CTRL = 15'h0029;
    localparam logic [14:0] ADDR_CLOCK_INPUT_CONTROL = 15'h002A;
    localparam logic [14:0] ADDR_SUPPLY_NOISE_CONTROL = 15'h002B;
    localparam logic [14:0] ADDR_EDGE_POS_B0 = 15'h002C;
    localparam logic [14:0] ADDR_EDGE_POS_B1 = 15'h002D;
    localparam logic [14:0] ADDR_EDGE_POS_B2 = 15'h002E;
    localparam logic [14:0] ADDR_FULLSCALE_B0 = 15'h0030;
    localparam logic [14:0] ADDR_FULLSCALE_B1 = 15'h0031;
    // Reset values
    localparam logic [7:0] RST_DELAY_CTRL = 8'h80;
    localparam logic [7:0] RST_CLOCK_INPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_SUPPLY_NOISE_CONTROL = 8'h10;
    localparam logic [23:0] RST_EDGE_POS = 24'h000000;
    localparam logic [15:0] RST_FULLSCALE = 16'hA000;
    // Field positions
    localparam int POS_ALIGNREF_INVERT = 0;
    localparam int POS_ALIGNREF_PECL = 1;
    localparam int POS_DEVCLOCK_PECL = 2;
    localparam int POS_CLOCK_RAIL_NS = 0;
    localparam int POS_QUIET_RAIL_NS = 2;
    localparam int POS_FINE_STEPS = 4;
    localparam int DELAY_SEL_MSB = 3;
    localparam int DELAY_SEL_W = 4;
    localparam int EDGE_POS_W = 24;
    localparam int FULLSCALE_W = 16;
endpackage : clk_regs_pkg

// ### inc/cfg_bus_if.sv
// Byte-wide register access between serial engine and register bank
`timescale 1ns/1ps
interface cfg_bus_if;
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport engine (output wr, output rd, output addr, output wdata, input rdata);
    modport bank (input wr, input rd, input addr, input wdata, output rdata);
endinterface : cfg_bus_if

// ### core/serial_cfg_port.sv
// Serial configuration port engine, oversampled on the system clock
`timescale 1ns/1ps
module serial_cfg_port
    import clk_regs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    cfg_bus_if.engine bus
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HEADER = 2'b01,
        ST_DATA = 2'b11
    } phase_t;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] sdi_s;
        phase_t phase;
        logic [4:0] cnt;
        logic [15:0] hdr;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic is_read;
        logic [14:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic sdo;
        logic sdo_oe;
    } port_state_t;

    port_state_t q;
    port_state_t d;
    logic rise;
    logic fall;
    logic [15:0] nh;
    logic [7:0] nb;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.sclk_s = {q.sclk_s[1:0], i_sclk};
        // Select kept active high so the reset value reads as deselected
        d.cs_s = {q.cs_s[0], ~i_cs_n};
        d.sdi_s = {q.sdi_s[0], i_sdi};
        d.wr = 1'b0;
        d.rd = 1'b0;
        rise = q.sclk_s[1] & ~q.sclk_s[2];
        fall = ~q.sclk_s[1] & q.sclk_s[2];
        nh = {q.hdr[14:0], q.sdi_s[1]};
        nb = {q.sh_in[6:0], q.sdi_s[1]};
        if (q.rd) begin
            d.sh_out = bus.rdata;
        end
        if (!q.cs_s[1]) begin
            d.phase = ST_IDLE;
            d.cnt = '0;
            d.sdo_oe = 1'b0;
        end else begin
            unique case (q.phase)
                ST_IDLE: begin
                    d.phase = ST_HEADER;
                    d.cnt = '0;
                end
                ST_HEADER: begin
                    if (rise) begin
                        d.hdr = nh;
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt == HDR_LAST) begin
                            d.phase = ST_DATA;
                            d.cnt = '0;
                            d.is_read = nh[RW_BIT];
                            d.addr = nh[ADDR_W-1:0];
                            d.rd = nh[RW_BIT];
                            d.sdo_oe = nh[RW_BIT];
                        end
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        d.sh_in = nb;
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt == BYTE_LAST) begin
                            d.cnt = '0;
                            d.wr = ~q.is_read;
                            d.wdata = nb;
                            d.addr = q.addr + 15'h0001;
                            d.rd = q.is_read;
                        end
                    end
                    if (fall && q.is_read) begin
                        d.sdo = q.sh_out[7];
                        d.sh_out = {q.sh_out[6:0], 1'b0};
                    end
                end
                default: d.phase = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Written byte goes to the address held before the increment
    assign bus.wr = q.wr;
    assign bus.rd = q.rd;
    assign bus.addr = q.wr ? q.addr - 15'h0001 : q.addr;
    assign bus.wdata = q.wdata;
    assign o_sdo = q.sdo;
    assign o_sdo_oe = q.sdo_oe;
endmodule : serial_cfg_port

// ### core/clock_sysref_range_regs.sv
// Clock input, alignment reference and full-scale register bank
//
// Behaviour
// - A set invert bit flips the alignment reference before it is used for alignment.
// - Bit 2 of the clock input control register puts the device clock input in PECL mode.
// - Bit 1 of the clock input control register puts the alignment reference input in PECL mode.
// - Bits 0 and 2 of the supply noise register enable clock-rail and quiet-rail suppression.
// - A read-only 24-bit status reports where the reference edge falls against the clock.
// - A 16-bit read-write full-scale code for all channels resets to A000 hex.
// - A 4-bit delay select field in the neighbouring register picks the sampling delay.
// - The fine-steps bit shrinks the windowing delay steps for status and delay select.
`timescale 1ns/1ps
module clock_sysref_range_regs
    import clk_regs_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_SCLK,
    input wire logic I_SCS_N,
    input wire logic I_SDI,
    output logic O_SDO,
    output logic O_SDO_OE,
    input wire logic I_ALIGNREF,
    input wire logic [23:0] I_ALIGNREF_EDGE_POS,
    output logic O_ALIGNREF,
    output logic O_DEVCLOCK_PECL_MODE,
    output logic O_ALIGNREF_PECL_MODE,
    output logic O_QUIET_RAIL_NOISE_SUPPRESS,
    output logic O_CLOCK_RAIL_NOISE_SUPPRESS,
    output logic [3:0] O_ALIGNREF_DELAY_SELECT,
    output logic O_ALIGNREF_FINE_STEPS,
    output logic [15:0] O_FULLSCALE_CODE
);
    typedef struct packed {
        logic [7:0] delay_ctrl;
        logic [7:0] clock_input_control;
        logic [7:0] supply_noise_control;
        logic [23:0] pos_s1;
        logic [23:0] alignref_edge_status;
        logic [15:0] fullscale_code;
        logic [1:0] ref_s;
        logic alignref;
    } bank_state_t;

    localparam bank_state_t BANK_RST = '{
        delay_ctrl: RST_DELAY_CTRL,
        clock_input_control: RST_CLOCK_INPUT_CONTROL,
        supply_noise_control: RST_SUPPLY_NOISE_CONTROL,
        pos_s1: RST_EDGE_POS,
        alignref_edge_status: RST_EDGE_POS,
        fullscale_code: RST_FULLSCALE,
        ref_s: 2'h0,
        alignref: 1'b0
    };

    bank_state_t q;
    bank_state_t d;
    cfg_bus_if bus ();

    ////////////////////////////////////////////////////////////////////////
    serial_cfg_port u_port (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_sclk(I_SCLK),
        .i_cs_n(I_SCS_N),
        .i_sdi(I_SDI),
        .o_sdo(O_SDO),
        .o_sdo_oe(O_SDO_OE),
        .bus(bus)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] read_byte(input logic [14:0] a, input bank_state_t s);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            ADDR_DELAY_CTRL: r = s.delay_ctrl;
            ADDR_CLOCK_INPUT_CONTROL: r = s.clock_input_control;
            ADDR_SUPPLY_NOISE_CONTROL: r = s.supply_noise_control;
            ADDR_EDGE_POS_B0: r = s.alignref_edge_status[7:0];
            ADDR_EDGE_POS_B1: r = s.alignref_edge_status[15:8];
            ADDR_EDGE_POS_B2: r = s.alignref_edge_status[23:16];
            ADDR_FULLSCALE_B0: r = s.fullscale_code[7:0];
            ADDR_FULLSCALE_B1: r = s.fullscale_code[15:8];
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_byte

    assign bus.rdata = read_byte(bus.addr, q);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        // Measurement is quasi-static; double registered before use
        d.pos_s1 = I_ALIGNREF_EDGE_POS;
        d.alignref_edge_status = q.pos_s1;
        d.ref_s = {q.ref_s[0], I_ALIGNREF};
        d.alignref = q.ref_s[1] ^ q.clock_input_control[POS_ALIGNREF_INVERT];
        if (bus.wr) begin
            unique case (bus.addr)
                ADDR_DELAY_CTRL: d.delay_ctrl = bus.wdata;
                ADDR_CLOCK_INPUT_CONTROL: d.clock_input_control = bus.wdata;
                ADDR_SUPPLY_NOISE_CONTROL: d.supply_noise_control = bus.wdata;
                ADDR_FULLSCALE_B0: d.fullscale_code[7:0] = bus.wdata;
                ADDR_FULLSCALE_B1: d.fullscale_code[15:8] = bus.wdata;
                default: d.delay_ctrl = q.delay_ctrl;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            q <= BANK_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign O_ALIGNREF = q.alignref;
    assign O_DEVCLOCK_PECL_MODE = q.clock_input_control[POS_DEVCLOCK_PECL];
    assign O_ALIGNREF_PECL_MODE = q.clock_input_control[POS_ALIGNREF_PECL];
    assign O_QUIET_RAIL_NOISE_SUPPRESS = q.supply_noise_control[POS_QUIET_RAIL_NS];
    assign O_CLOCK_RAIL_NOISE_SUPPRESS = q.supply_noise_control[POS_CLOCK_RAIL_NS];
    assign O_ALIGNREF_DELAY_SELECT = q.delay_ctrl[DELAY_SEL_MSB:0];
    assign O_ALIGNREF_FINE_STEPS = q.delay_ctrl[POS_FINE_STEPS];
    assign O_FULLSCALE_CODE = q.fullscale_code;
endmodule : clock_sysref_range_regs

// ### bench/clock_sysref_range_regs_checker.sv
// Port checker for the clock, alignment reference and full-scale bank
`timescale 1ns/1ps
module clock_sysref_range_regs_checker
    import clk_regs_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_SCLK,
    input wire logic I_SCS_N,
    input wire logic I_SDI,
    input wire logic O_SDO,
    input wire logic O_SDO_OE,
    input wire logic I_ALIGNREF,
    input wire logic [23:0] I_ALIGNREF_EDGE_POS,
    input wire logic O_ALIGNREF,
    input wire logic O_DEVCLOCK_PECL_MODE,
    input wire logic O_ALIGNREF_PECL_MODE,
    input wire logic O_QUIET_RAIL_NOISE_SUPPRESS,
    input wire logic O_CLOCK_RAIL_NOISE_SUPPRESS,
    input wire logic [3:0] O_ALIGNREF_DELAY_SELECT,
    input wire logic O_ALIGNREF_FINE_STEPS,
    input wire logic [15:0] O_FULLSCALE_CODE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    ////////////////////////////////////////////////////////////
    // No frame and no reset for eight cycles
    sequence quiet;
        (I_SCS_N && I_RSTN)[*8];
    endsequence
    sequence ref_moved;
        $past(I_ALIGNREF, 3) != $past(I_ALIGNREF, 4);
    endsequence
    sequence ref_still;
        $past(I_ALIGNREF, 3) == $past(I_ALIGNREF, 4);
    endsequence
    a_reset_fullscale: assert property ($rose(I_RSTN) |-> O_FULLSCALE_CODE == RST_FULLSCALE)
        else $error("fullscale code not at reset value");
    a_reset_controls: assert property ($rose(I_RSTN) |-> {O_DEVCLOCK_PECL_MODE,
        O_ALIGNREF_PECL_MODE, O_QUIET_RAIL_NOISE_SUPPRESS, O_CLOCK_RAIL_NOISE_SUPPRESS,
        O_ALIGNREF_FINE_STEPS, O_ALIGNREF_DELAY_SELECT} == 9'h000)
        else $error("control outputs not cleared by reset");
    a_ref_follows: assert property (quiet ##0 ref_moved |-> $changed(O_ALIGNREF))
        else $error("reference output missed an input edge");
    a_ref_steady: assert property (quiet ##0 ref_still |-> $stable(O_ALIGNREF))
        else $error("reference output moved without an input edge");
    a_controls_hold: assert property (quiet |-> $stable({O_DEVCLOCK_PECL_MODE,
        O_ALIGNREF_PECL_MODE, O_QUIET_RAIL_NOISE_SUPPRESS, O_CLOCK_RAIL_NOISE_SUPPRESS}))
        else $error("control output changed outside a frame");
    a_fullscale_hold: assert property (quiet |-> $stable(O_FULLSCALE_CODE))
        else $error("fullscale code changed outside a frame");
    a_delay_hold: assert property (quiet |-> $stable({O_ALIGNREF_DELAY_SELECT,
        O_ALIGNREF_FINE_STEPS})) else $error("delay select changed outside a frame");
    a_sdo_idle: assert property (quiet |-> !O_SDO_OE)
        else $error("serial data driven outside a frame");
endmodule : clock_sysref_range_regs_checker

bind clock_sysref_range_regs clock_sysref_range_regs_checker i_chk (.*);

// ### bench/clock_sysref_range_regs_bench.sv
// Self-checking bench for the clock, alignment reference and full-scale bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module clock_sysref_range_regs_bench import clk_regs_pkg::*;;
    logic I_CLK = 0, I_RSTN = 0, I_SCLK = 0, I_SCS_N = 1, I_SDI = 0, I_ALIGNREF = 0;
    logic [23:0] I_ALIGNREF_EDGE_POS = 24'h000000;
    logic O_SDO, O_SDO_OE, O_ALIGNREF, O_DEVCLOCK_PECL_MODE, O_ALIGNREF_PECL_MODE;
    logic O_QUIET_RAIL_NOISE_SUPPRESS, O_CLOCK_RAIL_NOISE_SUPPRESS, O_ALIGNREF_FINE_STEPS;
    logic [3:0] O_ALIGNREF_DELAY_SELECT;
    logic [15:0] O_FULLSCALE_CODE;
    logic [23:0] rd;
    logic [7:0] v;
    logic [15:0] c;
    int fails = 0, compares = 0, cyc = 0;
    always #5 I_CLK = ~I_CLK;
    clock_sysref_range_regs i_clock_sysref_range_regs (.*);
    ////////////////////////////////////////////////////////////
    task automatic cyc_n(input int n);
        repeat (n) @(posedge I_CLK);
    endtask : cyc_n
    // One frame: header, then n bytes at ascending addresses, low byte first
    task automatic xfer(input logic [15:0] hdr, input int n, input logic [23:0] wd,
            output logic [23:0] rv);
        logic [39:0] sh;
        sh = {hdr, 24'h000000};
        rv = 24'h000000;
        for (int k = 0; k < n; k++) sh[23 - 8 * k -: 8] = wd[8 * k +: 8];
        I_SCS_N <= 1'b0;
        cyc_n(4);
        for (int b = 0; b < 16 + 8 * n; b++) begin
            I_SCLK <= 1'b0;
            I_SDI <= sh[39 - b];
            cyc_n(10);
            if (b >= 16) rv[8 * ((b - 16) / 8) + 7 - (b % 8)] = O_SDO;
            if (b == 16) `CHK("sdo_oe", hdr[15], O_SDO_OE)
            I_SCLK <= 1'b1;
            cyc_n(10);
        end
        I_SCLK <= 1'b0;
        I_SCS_N <= 1'b1;
        cyc_n(12);
    endtask : xfer
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        cyc_n(20);
        I_RSTN <= 1'b1;
        `CHK("fs_port", RST_FULLSCALE, O_FULLSCALE_CODE)
        cyc_n(4);
        xfer(16'h8029, 3, 24'h000000, rd);
        `CHK("ctl_rst", 24'h100080, rd)
        xfer(16'h8030, 2, 24'h000000, rd);
        `CHK("fs_rst", RST_FULLSCALE, rd[15:0])
        // Each input-control bit alone, with the reference toggled
        for (int i = 0; i < 3; i++) begin
            v = 8'h01 << i;
            xfer(16'h002A, 1, {16'h0000, v}, rd);
            `CHK("pecl", v[2:1], {O_DEVCLOCK_PECL_MODE, O_ALIGNREF_PECL_MODE})
            I_ALIGNREF <= 1'b1;
            cyc_n(6);
            `CHK("ref_hi", ~v[0], O_ALIGNREF)
            I_ALIGNREF <= 1'b0;
            cyc_n(6);
            `CHK("ref_lo", v[0], O_ALIGNREF)
            xfer(16'h802A, 1, 24'h000000, rd);
            `CHK("rb_2a", v, rd[7:0])
        end
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h10 : 8'h15;
            xfer(16'h002B, 1, {16'h0000, v}, rd);
            `CHK("rails", {v[2], v[0]}, {O_QUIET_RAIL_NOISE_SUPPRESS,
                O_CLOCK_RAIL_NOISE_SUPPRESS})
        end
        xfer(16'h0029, 1, 24'h00009A, rd);
        `CHK("dly", 5'h1A, {O_ALIGNREF_FINE_STEPS, O_ALIGNREF_DELAY_SELECT})
        for (int i = 0; i < 2; i++) begin
            c = i ? 16'hFFFF : 16'h2000;
            xfer(16'h0030, 2, {8'h00, c}, rd);
            `CHK("fs_port", c, O_FULLSCALE_CODE)
            xfer(16'h8030, 2, 24'h000000, rd);
            `CHK("fs_rb", c, rd[15:0])
        end
        I_ALIGNREF_EDGE_POS <= 24'h5A3C81;
        cyc_n(4);
        xfer(16'h802C, 3, 24'h000000, rd);
        `CHK("pos", 24'h5A3C81, rd)
        xfer(16'h002C, 3, 24'h123456, rd);
        xfer(16'h802C, 3, 24'h000000, rd);
        `CHK("pos_wr", 24'h5A3C81, rd)
        I_ALIGNREF_EDGE_POS <= 24'hA5C37E;
        cyc_n(4);
        xfer(16'h802C, 3, 24'h000000, rd);
        `CHK("pos_new", 24'hA5C37E, rd)
        v = {4'h8, rd[3:0]};
        xfer(16'h0029, 1, {16'h0000, v}, rd);
        `CHK("dly_pick", v[4:0], {O_ALIGNREF_FINE_STEPS, O_ALIGNREF_DELAY_SELECT})
        xfer(16'h8040, 1, 24'h000000, rd);
        `CHK("unmapped", 8'h00, rd[7:0])
        finish_test();
    end
endmodule : clock_sysref_range_regs_bench
